// ==== design/bst_tap.sv ====
// bst_tap: boundary-scan test port with its serial output fifo.
// assumes test pins arrive asynchronously and are sampled by clk_i (50 MHz);
// the bench resolves the tdo wire from tdo_oe_o, and undriven tms/tdi
// are flagged low on the *_drv_i inputs.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// small fifo, width and depth as parameters
module bst_fifo #(
  parameter int W = 2,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;

  // handshake terms
  assign in_ready_o = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rp_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // pointers and count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= AW'(wp_reg + 1'b1);
      if (pop) rp_reg <= AW'(rp_reg + 1'b1);
      cnt_reg <= (AW+1)'(cnt_reg + push - pop);
    end
  end

  // storage
  always_ff @(posedge clk_i) begin
    if (push) mem_reg[wp_reg] <= in_data_i;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// test access port
module bst_tap (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tms_drv_i,
  input wire logic tdi_i,
  input wire logic tdi_drv_i,
  input wire logic [71:0] ring_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [71:0] bsr_par_o,
  output logic extest_o,
  output logic mem_out_hiz_o
);
  bst_pkg::bst_regs_t s_reg, s_next;
  logic tck_rise, tck_fall, rise_ok;
  logic fifo_in_ready, fifo_out_valid;
  logic [1:0] fifo_out_data, push_data;
  logic bsr_sel;

  // next controller state from mode select
  function automatic bst_pkg::bst_state_t next_st(
    input bst_pkg::bst_state_t st, input logic m);
    unique case (st)
      bst_pkg::ST_RESET: next_st = m ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: next_st = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: next_st = m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: next_st = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: next_st = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: next_st = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_PAU_DR: next_st = m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_EX2_DR: next_st = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: next_st = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: next_st = m ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: next_st = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: next_st = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: next_st = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_PAU_IR: next_st = m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_EX2_IR: next_st = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: next_st = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      default: next_st = bst_pkg::ST_RESET;
    endcase
  endfunction

  // instruction selects boundary register; others except idcode fall to bypass
  function automatic logic is_bsr(input logic [2:0] ins);
    is_bsr = (ins == bst_pkg::INS_EXTEST) || (ins == bst_pkg::INS_SAMPLE) ||
             (ins == bst_pkg::INS_SAMPLE_Z);
  endfunction

  // test clock edges seen through the synchroniser
  assign tck_rise = s_reg.tck_s[1] & ~s_reg.tck_s[2];
  assign tck_fall = ~s_reg.tck_s[1] & s_reg.tck_s[2];
  assign rise_ok = tck_rise & fifo_in_ready;
  assign bsr_sel = is_bsr(s_reg.ir);

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_next = s_reg;
    push_data = '0;
    // pins pass two flops; undriven pins read high
    s_next.tck_s = {s_reg.tck_s[1:0], tck_i};
    s_next.tms_s = {s_reg.tms_s[0], tms_i | ~tms_drv_i};
    s_next.tdi_s = {s_reg.tdi_s[0], tdi_i | ~tdi_drv_i};
    if (rise_ok) begin
      s_next.st = next_st(s_reg.st, s_reg.tms_s[1]);
      unique case (s_reg.st)
        bst_pkg::ST_CAP_IR:
          s_next.ir_sh = {1'b0, bst_pkg::IR_CAPTURE_PAT};
        bst_pkg::ST_SH_IR:
          s_next.ir_sh = {s_reg.tdi_s[1], s_reg.ir_sh[2:1]};
        bst_pkg::ST_UPD_IR: begin
          s_next.ir = s_reg.ir_sh;
          if (!is_bsr(s_reg.ir_sh) && s_reg.ir_sh != bst_pkg::INS_IDCODE)
            s_next.byp = 1'b0;
        end
        bst_pkg::ST_CAP_DR: begin
          if (bsr_sel) s_next.bsr_sh = ring_i;
          else if (s_reg.ir == bst_pkg::INS_IDCODE)
            s_next.id_sh = bst_pkg::ID_VALUE;
          else s_next.byp = 1'b0;
        end
        bst_pkg::ST_SH_DR: begin
          if (bsr_sel)
            s_next.bsr_sh = {s_reg.tdi_s[1], s_reg.bsr_sh[71:1]};
          else if (s_reg.ir == bst_pkg::INS_IDCODE)
            s_next.id_sh = {s_reg.tdi_s[1], s_reg.id_sh[31:1]};
          else s_next.byp = s_reg.tdi_s[1];
        end
        bst_pkg::ST_UPD_DR:
          if (bsr_sel) s_next.bsr_upd = s_reg.bsr_sh;
        default: ;
      endcase
      // reset state forces the identification instruction
      if (s_next.st == bst_pkg::ST_RESET) s_next.ir = bst_pkg::INS_IDCODE;
      // output bit staged for the next fall
      if (s_next.st == bst_pkg::ST_SH_IR)
        push_data = {1'b1, s_next.ir_sh[0]};
      else if (s_next.st == bst_pkg::ST_SH_DR) begin
        if (bsr_sel) push_data = {1'b1, s_next.bsr_sh[0]};
        else if (s_reg.ir == bst_pkg::INS_IDCODE)
          push_data = {1'b1, s_next.id_sh[0]};
        else push_data = {1'b1, s_next.byp};
      end
    end
    // serial output changes only on the falling test edge
    if (tck_fall && fifo_out_valid) begin
      s_next.tdo_oe = fifo_out_data[1];
      s_next.tdo = fifo_out_data[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; power-up resets the port alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '{st: bst_pkg::ST_RESET, ir: bst_pkg::INS_IDCODE,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // one staged output bit per rise, drained at the fall
  bst_fifo #(
    .W(bst_pkg::OUT_FIFO_W),
    .D(bst_pkg::OUT_FIFO_D)
  ) u_out_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(push_data),
    .in_valid_i(rise_ok),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(tck_fall)
  );

  // outputs
  assign tdo_o = s_reg.tdo;
  assign tdo_oe_o = s_reg.tdo_oe;
  assign bsr_par_o = s_reg.bsr_upd;
  assign extest_o = (s_reg.ir == bst_pkg::INS_EXTEST);
  // memory outputs float under sample-z while boundary shifts
  assign mem_out_hiz_o = (s_reg.ir == bst_pkg::INS_SAMPLE_Z) &&
                         (s_reg.st == bst_pkg::ST_SH_DR);

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [2:0] hi_cnt_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) hi_cnt_reg <= '0;
    else if (rise_ok)
      hi_cnt_reg <= s_reg.tms_s[1] ? ((hi_cnt_reg == 3'h5) ? 3'h5 :
                                      3'(hi_cnt_reg + 1'b1)) : 3'h0;
  end

  a_tms_five_reset: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    hi_cnt_reg == 3'h5 |-> s_reg.st == bst_pkg::ST_RESET)
    else $error("five high mode selects did not reset");
  a_reset_idcode: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_reg.st == bst_pkg::ST_RESET |-> s_reg.ir == bst_pkg::INS_IDCODE)
    else $error("reset state without identification instruction");
  a_ir_capture_pat: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_ok && s_reg.st == bst_pkg::ST_CAP_IR |=>
      s_reg.ir_sh[1:0] == bst_pkg::IR_CAPTURE_PAT)
    else $error("instruction capture pattern wrong");
  a_ir_hold_shift: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_reg.st == bst_pkg::ST_SH_IR |=> $stable(s_reg.ir))
    else $error("instruction changed while shifting");
  a_bypass_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_ok && s_reg.st == bst_pkg::ST_UPD_IR &&
      s_reg.ir_sh == bst_pkg::INS_BYPASS |=> !s_reg.byp)
    else $error("bypass bit not cleared");
  a_id_capture: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_ok && s_reg.st == bst_pkg::ST_CAP_DR &&
      s_reg.ir == bst_pkg::INS_IDCODE |=> s_reg.id_sh == bst_pkg::ID_VALUE)
    else $error("identification value not captured");
  a_bsr_msb_in: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_ok && s_reg.st == bst_pkg::ST_SH_DR && bsr_sel |=>
      s_reg.bsr_sh[71] == $past(s_reg.tdi_s[1]))
    else $error("serial bit not at msb");
  a_tdo_on_fall: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !tck_fall |=> $stable(s_reg.tdo_oe) && $stable(s_reg.tdo))
    else $error("serial output moved off the falling edge");
  a_oe_shift_only: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    tck_fall |=> s_reg.tdo_oe == ($past(s_reg.st) == bst_pkg::ST_SH_IR ||
      $past(s_reg.st) == bst_pkg::ST_SH_DR))
    else $error("serial output driven outside shift");

  // scan path entry, bypass behaviour and parallel update hold
  a_ir_msb_in: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_ok && s_reg.st == bst_pkg::ST_SH_IR |=>
      s_reg.ir_sh[2] == $past(s_reg.tdi_s[1]))
    else $error("instruction bit not at msb");
  a_byp_shift_in: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_ok && s_reg.st == bst_pkg::ST_SH_DR && !bsr_sel &&
      s_reg.ir != bst_pkg::INS_IDCODE |=>
      s_reg.byp == $past(s_reg.tdi_s[1]))
    else $error("bypass bit did not take the serial input");
  a_byp_capture: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_ok && s_reg.st == bst_pkg::ST_CAP_DR && !bsr_sel &&
      s_reg.ir != bst_pkg::INS_IDCODE |=> !s_reg.byp)
    else $error("bypass bit not cleared at capture");
  a_bsr_upd_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !(rise_ok && s_reg.st == bst_pkg::ST_UPD_DR) |=>
      $stable(s_reg.bsr_upd))
    else $error("parallel boundary outputs moved outside update");
endmodule

// ==== design/bst_pkg.sv ====
// bst_pkg: constants and types shared by the boundary-scan test port.
// assumes a single system clock domain; the test clock is a sampled input.
package bst_pkg;

  // instruction codes, three bits wide
  localparam int IR_W = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  // pattern forced into the low instruction bits at capture
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

  // identification register; value is arbitrary, bit 0 set as required
  localparam int ID_W = 32;
  localparam logic [31:0] ID_VALUE = 32'h0000_1001;

  // boundary cells: one per memory input and bidirectional pin
  localparam int BSR_W = 72;

  // serial output stage fifo
  localparam int OUT_FIFO_W = 2;
  localparam int OUT_FIFO_D = 8;

  // controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bst_state_t;

  // whole state of the port apart from the output fifo
  typedef struct packed {
    bst_state_t st;
    logic [2:0] ir_sh;
    logic [2:0] ir;
    logic byp;
    logic [31:0] id_sh;
    logic [71:0] bsr_sh;
    logic [71:0] bsr_upd;
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic tdo;
    logic tdo_oe;
  } bst_regs_t;

endpackage

// ==== dv/bst_ctl_model.sv ====
// bst_ctl_model: scan controller that drives the far side of the test port.
// assumes tdo_i is the resolved pin, z while the port floats it.
`timescale 1ns/1ps
module bst_ctl_model (
  output logic tck_o,
  output logic tms_o,
  output logic tms_drv_o,
  output logic tdi_o,
  output logic tdi_drv_o,
  input wire logic tdo_i
);
  localparam time HALF_T = 80ns;

  ////////////////////////////////////////////////////////////////////////////
  // idle pins; test clock parked low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tms_drv_o = 1'b1;
    tdi_o = 1'b1;
    tdi_drv_o = 1'b1;
  end

  // one test clock period: pins set in low phase, tdo read late in high
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms_drv_o ? tms : ~tms_o; // released pin keeps toggling
    tdi_o = tdi_drv_o ? tdi : ~tdi_o;
    #(HALF_T);
    tck_o = 1'b1;
    #(HALF_T);
    tdo = tdo_i;
    tck_o = 1'b0;
  endtask

  // five rises with mode select high, then park in idle
  task automatic tap_reset();
    logic d;
    repeat (5) step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
  endtask

  // idle to idle scan of n bits, lsb first; oe_ok low if tdo floated
  task automatic scan(input logic ir, input int n, input logic [71:0] din,
                      output logic [71:0] dout, output logic oe_ok);
    logic d;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b0, d);
    if (ir) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
      if (d !== 1'b0 && d !== 1'b1) oe_ok = 1'b0;
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
endmodule

// ==== dv/tb_top.sv ====
// tb_top: self-checking bench for the boundary-scan test port.
// assumes the controller model owns the test pins; ring is held steady.
`timescale 1ns/1ps
module tb_top;
  localparam logic [71:0] RING_PAT = 72'hA5_3C96_0FF0_1234_5678;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [71:0] ring_i = RING_PAT;
  logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, extest, mem_hiz;
  logic hiz_seen = 1'b0;
  logic oe_ok;
  logic [71:0] bsr_par, got;
  wire tdo_w;
  int failures = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, resolved tdo pin, float monitor
  always #10 clk_i = ~clk_i;
  assign tdo_w = tdo_oe ? tdo : 1'bz;
  always @(posedge clk_i) if (mem_hiz === 1'b1) hiz_seen <= 1'b1;

  bst_tap uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
    .tms_drv_i(tms_drv), .tdi_i(tdi), .tdi_drv_i(tdi_drv), .ring_i(ring_i),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .bsr_par_o(bsr_par),
    .extest_o(extest), .mem_out_hiz_o(mem_hiz)
  );

  bst_ctl_model ctl (
    .tck_o(tck), .tms_o(tms), .tms_drv_o(tms_drv), .tdi_o(tdi),
    .tdi_drv_o(tdi_drv), .tdo_i(tdo_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic check(input string what, input logic [71:0] exp,
                       input logic [71:0] seen);
    samples_checked++;
    if (exp !== seen) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  // id value after power-up; tdo floats outside shift
  task automatic t_idcode();
    check("tdo_oe at reset", 72'(tdo_oe), 72'h0);
    check("extest at reset", 72'(extest), 72'h0);
    ctl.tap_reset();
    ctl.scan(1'b0, 32, '0, got, oe_ok);
    check("id value", 72'(bst_pkg::ID_VALUE), got);
    check("tdo driven in shift", 72'h1, 72'(oe_ok));
    check("tdo_oe in idle", 72'h0, 72'(tdo_oe));
  endtask

  // capture pattern, then bypass bit cleared and one stage of delay
  task automatic t_bypass(input logic [2:0] code);
    ctl.scan(1'b1, 3, 72'(code), got, oe_ok);
    check("ir capture", 72'h1, 72'(got[1:0]));
    ctl.scan(1'b0, 4, 72'hB, got, oe_ok);
    check("bypass path", 72'h6, got);
  endtask

  // ring capture, parallel update and instruction side outputs
  task automatic t_boundary(input logic [2:0] code);
    logic [71:0] din;
    din = ~RING_PAT ^ 72'(code);
    ctl.scan(1'b1, 3, 72'(code), got, oe_ok);
    hiz_seen = 1'b0;
    ctl.scan(1'b0, 72, din, got, oe_ok);
    check("ring capture", RING_PAT, got);
    check("parallel update", din, bsr_par);
    check("extest flag", 72'(code == bst_pkg::INS_EXTEST),
          72'(extest));
    check("outputs float", 72'(code == bst_pkg::INS_SAMPLE_Z),
          72'(hiz_seen));
  endtask

  // released mode select resets the port, released data input gives ones
  task automatic t_pullups();
    logic d;
    ctl.scan(1'b1, 3, 72'(bst_pkg::INS_BYPASS), got, oe_ok);
    ctl.tms_drv_o = 1'b0;
    repeat (5) ctl.step(1'b0, 1'b0, d);
    ctl.tms_drv_o = 1'b1;
    ctl.step(1'b0, 1'b0, d);
    ctl.tdi_drv_o = 1'b0;
    ctl.scan(1'b0, 34, '0, got, oe_ok);
    ctl.tdi_drv_o = 1'b1;
    check("id after reset", {38'h0, 2'h3, bst_pkg::ID_VALUE}, got);
    check("hiz after reset", 72'h0, 72'(mem_hiz));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #2; // test pins move just after a clock edge from here on
    t_idcode();
    t_bypass(bst_pkg::INS_BYPASS);
    t_bypass(3'h3);
    t_bypass(3'h5);
    t_bypass(3'h6);
    t_boundary(bst_pkg::INS_SAMPLE);
    t_boundary(bst_pkg::INS_EXTEST);
    t_boundary(bst_pkg::INS_SAMPLE_Z);
    t_pullups();
    summarize();
  end

  initial begin
    #400000; // about 20000 clock cycles
    failures++;
    summarize();
  end
endmodule
